// [gtc_consts.vh]
// Functional notes
// - 16-bit up-counter with high and low byte writes replacing the count at once
// - timer-on clear stops counting; gate-enable clear counts always; both set obeys gate
// - clock select 01 fosc, 00 fosc/4, 11 cap osc, 10 pin or crystal
// - instruction clock source advances once per instruction cycle through prescaler
// - fosc source advances four counts per instruction cycle
// - external sources count rising edges, synchronised or asynchronous
// - external counting needs a falling edge after enable or count write
// - prescaler divides the selected clock by 1, 2, 4 or 8
// - prescaler hidden from software and cleared on any count byte write
// - crystal oscillator runs while enabled, also during sleep
// - sync-disable counts external clock unsynchronised, runs in sleep, overflow wakes
// - switching sync modes may lose or add one increment, tolerated
// - byte reads always see a settled value, even when counting asynchronously
// - in gate mode count only while gate level equals polarity, else hold
// - gate select 00 pin, 01 timer zero overflow, 10 comp1, 11 comp2
// - timer zero rollover pulse feeds the gate when selected
// - each comparator gate source selectable synchronised or raw
// - rollover from ffff to 0000 sets overflow flag, software clears
// - falling edge of gate value status sets gate event flag, always
// - single pulse mode counts one gate pulse then clears the go bit
// - toggle mode flips gate flip-flop per rising edge; disable holds it clear
`ifndef GTC_CONSTS_VH
`define GTC_CONSTS_VH

`define GTC_FOSC_PERIOD_NS 10
`define GTC_INSTR_DIV 4
`define GTC_INSTR_LAST 2'h3

`define GTC_CS_INSTR 2'h0
`define GTC_CS_FOSC 2'h1
`define GTC_CS_EXT 2'h2
`define GTC_CS_CAP 2'h3

`define GTC_GS_PIN 2'h0
`define GTC_GS_T0OVF 2'h1
`define GTC_GS_CMP1 2'h2
`define GTC_GS_CMP2 2'h3

`define GTC_COUNT_RESET 16'h0000
`define GTC_COUNT_MAX 16'hffff
`define GTC_PRESC_RESET 3'h0

`endif

// [gtc_timer.v]
`timescale 1ns/10ps
`default_nettype none
`include "gtc_consts.vh"

module gtc_timer #(
    parameter WIDTH = 16,
    parameter PRESC_BITS = 3
) (
    input wire ref_clk,
    input wire rst,
    // control bits
    input wire timer_on_bit,
    input wire gate_enable_bit,
    input wire [1:0] clock_select_field,
    input wire crystal_osc_enable,
    input wire [1:0] prescale_field,
    input wire sync_disable_bit,
    input wire gate_polarity_bit,
    input wire [1:0] gate_source_select,
    input wire gate_toggle_enable,
    input wire single_pulse_enable,
    input wire single_pulse_go_set,
    input wire single_pulse_go_clear,
    input wire cmp1_sync_select,
    input wire cmp2_sync_select,
    input wire overflow_flag_clear,
    input wire gate_event_flag_clear,
    input wire sleep_mode,
    // count byte writes
    input wire count_high_write,
    input wire count_low_write,
    input wire [7:0] count_write_data,
    // pins and neighbour signals
    input wire ext_clock_pin,
    input wire cap_osc_clock,
    input wire crystal_in_pin,
    input wire gate_pin,
    input wire comparator1_out,
    input wire comparator2_out,
    input wire eight_bit_timer_zero_overflow,
    // outputs
    output wire crystal_out_pin,
    output wire crystal_out_oe,
    output wire crystal_osc_running,
    output wire [7:0] count_high_byte,
    output wire [7:0] count_low_byte,
    output wire gate_value_status,
    output wire single_pulse_go,
    output wire overflow_flag,
    output wire gate_event_flag,
    output wire wake_pulse
);

    reg [1:0] instr_cnt_q;
    reg [1:0] ext_s1_q, ext_s2_q, ext_s3_q;
    reg [1:0] gate_s1_q, gate_s2_q;
    reg [1:0] cmp_s1_q, cmp_s2_q;
    reg [WIDTH-1:0] count_q, count_d;
    reg [PRESC_BITS-1:0] presc_q;
    reg armed_q;
    reg sync_pend_q;
    reg gsync1_q, gsync2_q;
    reg cmp1_hold_q, cmp2_hold_q;
    reg toggle_q;
    reg gval_q;
    reg go_q;
    reg ovf_flag_q, gate_flag_q, wake_q;
    reg run_prev_q;
    reg [PRESC_BITS-1:0] presc_mask;
    reg src_tick;
    reg gate_raw;

    wire instr_en;
    wire count_write;
    wire ext_sel;
    wire ext_clk_s, ext_clk_prev;
    wire ext_rise, ext_fall;
    wire presc_tick;
    wire permit;
    wire run;
    wire inc;
    wire gate_level;
    wire gate_rise;

    // instruction cycle enable: one pulse every four system clocks
    always @(posedge ref_clk) begin
        if (rst) begin
            instr_cnt_q <= 2'h0;
        end else begin
            instr_cnt_q <= instr_cnt_q + 2'h1;
        end
    end
    assign instr_en = (instr_cnt_q == `GTC_INSTR_LAST);

    // crystal amplifier: inverting stage, live regardless of sleep
    assign crystal_out_pin = ~ext_s2_q[1];
    assign crystal_out_oe = crystal_osc_enable;
    assign crystal_osc_running = crystal_osc_enable;

    // pin synchronisers: bit 0 ext/cap clock, bit 1 crystal input
    always @(posedge ref_clk) begin
        if (rst) begin
            ext_s1_q <= 2'h0;
            ext_s2_q <= 2'h0;
            ext_s3_q <= 2'h0;
            gate_s1_q <= 2'h0;
            gate_s2_q <= 2'h0;
        end else begin
            ext_s1_q <= {crystal_in_pin,
                (clock_select_field == `GTC_CS_CAP) ? cap_osc_clock : ext_clock_pin};
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            gate_s1_q <= {comparator1_out ^ comparator2_out ^ 1'b0, gate_pin};
            gate_s2_q <= gate_s1_q;
        end
    end

    // selected external clock after synchronisers
    assign ext_sel = clock_select_field[1];
    assign ext_clk_s = (clock_select_field == `GTC_CS_EXT && crystal_osc_enable) ?
        ext_s2_q[1] : ext_s2_q[0];
    assign ext_clk_prev = (clock_select_field == `GTC_CS_EXT && crystal_osc_enable) ?
        ext_s3_q[1] : ext_s3_q[0];
    assign ext_rise = ext_clk_s & ~ext_clk_prev;
    assign ext_fall = ~ext_clk_s & ext_clk_prev;

    // falling-edge arming for external counting
    always @(posedge ref_clk) begin
        if (rst) begin
            armed_q <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= timer_on_bit;
            if (count_write || !timer_on_bit) begin
                armed_q <= 1'b0;
            end else if (ext_fall) begin
                armed_q <= 1'b1;
            end
        end
    end

    // sync mode holds an external edge until the next instruction cycle;
    // switching modes may drop or double one edge, which is accepted
    always @(posedge ref_clk) begin
        if (rst) begin
            sync_pend_q <= 1'b0;
        end else if (sync_disable_bit || count_write) begin
            sync_pend_q <= 1'b0;
        end else if (instr_en) begin
            sync_pend_q <= 1'b0; // an edge on the enable itself counts now, not twice
        end else if (ext_rise && armed_q) begin
            sync_pend_q <= 1'b1;
        end
    end

    // clock source decode; only unsynchronised external counting survives sleep
    always @* begin
        src_tick = 1'b0;
        case (clock_select_field)
            `GTC_CS_FOSC: src_tick = ~sleep_mode;
            `GTC_CS_INSTR: src_tick = instr_en & ~sleep_mode;
            `GTC_CS_EXT, `GTC_CS_CAP: begin
                if (sync_disable_bit) begin
                    src_tick = ext_rise & armed_q;
                end else begin
                    src_tick = (sync_pend_q | (ext_rise & armed_q)) & instr_en
                        & ~sleep_mode;
                end
            end
            default: src_tick = 1'b0;
        endcase
    end

    // prescale mask for 1, 2, 4 or 8
    always @* begin
        case (prescale_field)
            2'h0: presc_mask = 3'h0;
            2'h1: presc_mask = 3'h1;
            2'h2: presc_mask = 3'h3;
            2'h3: presc_mask = 3'h7;
            default: presc_mask = 3'h0;
        endcase
    end
    assign presc_tick = src_tick && ((presc_q & presc_mask) == presc_mask);

    // prescale counter, not visible to software
    always @(posedge ref_clk) begin
        if (rst) begin
            presc_q <= `GTC_PRESC_RESET;
        end else if (count_write) begin
            presc_q <= `GTC_PRESC_RESET;
        end else if (src_tick && timer_on_bit) begin
            presc_q <= presc_q + 3'h1;
        end
    end

    // gate source mux; comparators either raw or held at counting edges
    always @* begin
        case (gate_source_select)
            `GTC_GS_PIN: gate_raw = gate_s2_q[0];
            `GTC_GS_T0OVF: gate_raw = eight_bit_timer_zero_overflow;
            `GTC_GS_CMP1: gate_raw = cmp1_sync_select ? cmp1_hold_q : cmp_raw(1'b0, cmp_s2_q);
            `GTC_GS_CMP2: gate_raw = cmp2_sync_select ? cmp2_hold_q : cmp_raw(1'b1, cmp_s2_q);
            default: gate_raw = 1'b0;
        endcase
    end

    // comparator raw inputs after the pin synchronisers
    always @(posedge ref_clk) begin
        if (rst) begin
            cmp_s1_q <= 2'h0;
            cmp_s2_q <= 2'h0;
        end else begin
            cmp_s1_q <= {comparator2_out, comparator1_out};
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // the vector is an argument so that the caller's sensitivity list sees it
    function cmp_raw;
        input sel;
        input [1:0] v;
        begin
            cmp_raw = sel ? v[1] : v[0];
        end
    endfunction

    // timer-clock synchronised comparator copies
    always @(posedge ref_clk) begin
        if (rst) begin
            cmp1_hold_q <= 1'b0;
            cmp2_hold_q <= 1'b0;
        end else if (src_tick) begin
            cmp1_hold_q <= cmp_s2_q[0];
            cmp2_hold_q <= cmp_s2_q[1];
        end
    end

    // two stages on the counting clock; overflow pulses are stretched
    // by sampling them every system clock while no tick arrives
    always @(posedge ref_clk) begin
        if (rst) begin
            gsync1_q <= 1'b0;
            gsync2_q <= 1'b0;
        end else begin
            if (src_tick || gate_raw) begin
                gsync1_q <= gate_raw;
            end
            if (src_tick) begin
                gsync2_q <= gsync1_q;
            end
        end
    end
    assign gate_rise = gsync1_q & ~gsync2_q & src_tick;

    // toggle flip-flop, held clear while toggle mode is off
    always @(posedge ref_clk) begin
        if (rst) begin
            toggle_q <= 1'b0;
        end else if (!gate_toggle_enable) begin
            toggle_q <= 1'b0;
        end else if (gate_rise) begin
            toggle_q <= ~toggle_q;
        end
    end

    // gate level against polarity; valid even with gate mode off
    assign gate_level = gate_toggle_enable ? toggle_q : gsync2_q;
    always @(posedge ref_clk) begin
        if (rst) begin
            gval_q <= 1'b0;
        end else begin
            gval_q <= ~(gate_level ^ gate_polarity_bit);
        end
    end
    assign gate_value_status = gval_q;

    // single pulse go bit: set by software, cleared at the trailing edge
    always @(posedge ref_clk) begin
        if (rst) begin
            go_q <= 1'b0;
        end else if (single_pulse_go_set) begin
            go_q <= 1'b1;
        end else if (single_pulse_go_clear) begin
            go_q <= 1'b0;
        end else if (single_pulse_enable && go_q && gval_q && !gate_value_d(1'b0)) begin
            go_q <= 1'b0;
        end
    end

    function gate_value_d;
        input dummy;
        begin
            gate_value_d = ~(gate_level ^ gate_polarity_bit);
        end
    endfunction

    // count permission
    assign permit = gval_q & (~single_pulse_enable | go_q);
    assign run = timer_on_bit & (~gate_enable_bit | permit);
    assign inc = run & presc_tick;
    assign count_write = count_high_write | count_low_write;

    // counter next value; byte writes win over an increment
    always @* begin
        count_d = count_q;
        if (count_write) begin
            if (count_high_write) begin
                count_d[15:8] = count_write_data;
            end
            if (count_low_write) begin
                count_d[7:0] = count_write_data;
            end
        end else if (inc) begin
            count_d = count_q + 16'h0001;
        end
    end

    // counter register; reads come straight from it, always settled
    always @(posedge ref_clk) begin
        if (rst) begin
            count_q <= `GTC_COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end
    assign count_high_byte = count_q[15:8];
    assign count_low_byte = count_q[7:0];

    // sticky flags: hardware set beats software clear
    always @(posedge ref_clk) begin
        if (rst) begin
            ovf_flag_q <= 1'b0;
            gate_flag_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            wake_q <= 1'b0;
            if (inc && !count_write && count_q == `GTC_COUNT_MAX) begin
                ovf_flag_q <= 1'b1;
                wake_q <= sleep_mode;
            end else if (overflow_flag_clear) begin
                ovf_flag_q <= 1'b0;
            end
            if (gval_q && !gate_value_d(1'b0)) begin
                gate_flag_q <= 1'b1;
            end else if (gate_event_flag_clear) begin
                gate_flag_q <= 1'b0;
            end
        end
    end
    assign overflow_flag = ovf_flag_q;
    assign gate_event_flag = gate_flag_q;
    assign wake_pulse = wake_q;
    assign single_pulse_go = go_q;

endmodule

`default_nettype wire

// [gtc_timer_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic timer_on_bit,
    input wire logic gate_enable_bit,
    input wire logic [1:0] clock_select_field,
    input wire logic [1:0] prescale_field,
    input wire logic sleep_mode,
    input wire logic count_high_write,
    input wire logic count_low_write,
    input wire logic [7:0] count_write_data,
    input wire logic overflow_flag,
    input wire logic gate_value_status,
    input wire logic gate_event_flag,
    input wire logic [7:0] count_high_byte,
    input wire logic [7:0] count_low_byte
);
    wire [15:0] cnt = {count_high_byte, count_low_byte};
    wire wr = count_high_write | count_low_write;
    logic [15:0] cnt_q;
    wire inc = (cnt == cnt_q + 16'h1);
    // last count, so that a single increment can be told apart
    always @(posedge ref_clk) begin
        cnt_q <= cnt;
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // settings are held one cycle earlier too, since the count lags its cause
    off_hold_a: assert property ((!timer_on_bit && !wr)[*3] |=> $stable(cnt))
        else $error("count moved while off");
    high_write_a: assert property (count_high_write |=> count_high_byte == $past(count_write_data))
        else $error("high byte write lost");
    low_write_a: assert property (count_low_write |=> count_low_byte == $past(count_write_data))
        else $error("low byte write lost");
    fosc_step_a: assert property (timer_on_bit && !gate_enable_bit && clock_select_field == 2'h1
        && prescale_field == 2'h0 && !sleep_mode && !wr && !$past(wr) && $stable(timer_on_bit)
        && $stable(gate_enable_bit) && $stable(clock_select_field) && $stable(prescale_field)
        |=> inc)
        else $error("fosc count missed");
    instr_gap_a: assert property (clock_select_field == 2'h0 && $stable(clock_select_field)
        && inc && !$past(wr) |=> !inc || $past(wr))
        else $error("instruction count too fast");
    wrap_flag_a: assert property (cnt == 16'hffff ##1 (cnt == 16'h0000 && !$past(wr))
        |-> ##[0:1] overflow_flag)
        else $error("rollover flag missing");
    gate_event_a: assert property ($fell(gate_value_status) |-> ##[0:1] gate_event_flag)
        else $error("gate event flag missing");
    gate_hold_a: assert property ((gate_enable_bit && !gate_value_status && !wr)[*3]
        |=> $stable(cnt))
        else $error("count moved with gate shut");
    cover property (inc && clock_select_field == 2'h2);
    cover property ($rose(overflow_flag));
    cover property ($fell(gate_value_status));
endmodule
bind gtc_timer gtc_timer_chk u_chk (.ref_clk, .rst, .timer_on_bit, .gate_enable_bit,
    .clock_select_field, .prescale_field, .sleep_mode, .count_high_write, .count_low_write,
    .count_write_data, .overflow_flag, .gate_value_status, .gate_event_flag,
    .count_high_byte, .count_low_byte);
`default_nettype wire

// [gtc_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module gtc_far_model (
    input wire logic ref_clk,
    output wire logic ext_clock_pin,
    output wire logic cap_osc_clock,
    output wire logic crystal_in_pin,
    output wire logic gate_pin,
    output wire logic comparator1_out,
    output wire logic comparator2_out,
    output wire logic eight_bit_timer_zero_overflow
);
    logic [2:0] clk_q = 3'h0;
    logic [2:0] lvl_q = 3'h0;
    logic t0_q = 1'b0;
    // clocks stand still low between bursts, levels hold until changed
    assign {crystal_in_pin, cap_osc_clock, ext_clock_pin} = clk_q;
    assign {comparator2_out, comparator1_out, gate_pin} = lvl_q;
    assign eight_bit_timer_zero_overflow = t0_q;
    // n rising edges on one source, slow enough for synchronised counting
    task automatic burst(input int src, input int n);
        repeat (n) begin
            clk_q[src] = 1'b1;
            repeat (4) @(negedge ref_clk);
            clk_q[src] = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
    endtask
    task automatic levels(input logic [2:0] v);
        lvl_q = v;
    endtask
    // one-cycle pulse per rollover of the neighbour timer
    task automatic t0_rolls(input int n);
        repeat (n) begin
            t0_q = 1'b1;
            @(negedge ref_clk);
            t0_q = 1'b0;
            repeat (3) @(negedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

// [test_gated_16bit_timer_counter.sv]
`timescale 1ns/10ps
`default_nettype none
module test_gated_16bit_timer_counter;
    logic ref_clk, rst, timer_on_bit, gate_enable_bit, crystal_osc_enable, sync_disable_bit;
    logic gate_polarity_bit, gate_toggle_enable, single_pulse_enable, single_pulse_go_set;
    logic single_pulse_go_clear, cmp1_sync_select, cmp2_sync_select, overflow_flag_clear;
    logic gate_event_flag_clear, sleep_mode, count_high_write, count_low_write;
    logic [1:0] clock_select_field, prescale_field, gate_source_select;
    logic [7:0] count_write_data;
    wire ext_clock_pin, cap_osc_clock, crystal_in_pin, gate_pin, comparator1_out;
    wire comparator2_out, eight_bit_timer_zero_overflow, crystal_out_pin, crystal_out_oe;
    wire crystal_osc_running, gate_value_status, single_pulse_go, overflow_flag;
    wire gate_event_flag, wake_pulse;
    wire [7:0] count_high_byte, count_low_byte;
    wire [15:0] cnt = {count_high_byte, count_low_byte};
    logic [15:0] base;
    logic [2:0] m;
    int err_total = 0;
    int n_tests = 0;
    int n_wake = 0;
    int wake0;
    gtc_timer DUT (.ref_clk, .rst, .timer_on_bit, .gate_enable_bit, .clock_select_field,
        .crystal_osc_enable, .prescale_field, .sync_disable_bit, .gate_polarity_bit,
        .gate_source_select, .gate_toggle_enable, .single_pulse_enable, .single_pulse_go_set,
        .single_pulse_go_clear, .cmp1_sync_select, .cmp2_sync_select, .overflow_flag_clear,
        .gate_event_flag_clear, .sleep_mode, .count_high_write, .count_low_write,
        .count_write_data, .ext_clock_pin, .cap_osc_clock, .crystal_in_pin, .gate_pin,
        .comparator1_out, .comparator2_out, .eight_bit_timer_zero_overflow, .crystal_out_pin,
        .crystal_out_oe, .crystal_osc_running, .count_high_byte, .count_low_byte,
        .gate_value_status, .single_pulse_go, .overflow_flag, .gate_event_flag, .wake_pulse);
    gtc_far_model far (.ref_clk, .ext_clock_pin, .cap_osc_clock, .crystal_in_pin, .gate_pin,
        .comparator1_out, .comparator2_out, .eight_bit_timer_zero_overflow);
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rate(input int n, input logic [15:0] want);
        base = cnt;
        step(n);
        check(cnt - base, want);
    endtask
    // one data bus, so the two bytes go in on successive cycles
    task automatic put(input logic [7:0] hi, input logic [7:0] lo);
        count_write_data = hi;
        count_high_write = 1'b1;
        step(1);
        count_write_data = lo;
        {count_high_write, count_low_write} = 2'h1;
        step(1);
        count_low_write = 1'b0;
    endtask
    // wake pulses last one cycle, so they are tallied as they come
    always @(posedge ref_clk) begin
        if (wake_pulse === 1'b1) begin
            n_wake <= n_wake + 1;
        end
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard, well beyond the 1700 or so cycles the tests take
    initial begin
        step(20000);
        err_total++;
        $display("Error %0t: timeout", $time);
        report_and_stop();
    end
    initial begin
        {timer_on_bit, gate_enable_bit, crystal_osc_enable, sync_disable_bit, gate_polarity_bit,
            gate_toggle_enable, single_pulse_enable, single_pulse_go_set, single_pulse_go_clear,
            cmp1_sync_select, cmp2_sync_select, overflow_flag_clear, gate_event_flag_clear,
            sleep_mode, count_high_write, count_low_write, clock_select_field, prescale_field,
            gate_source_select, count_write_data} = '0;
        rst = 1'b1;
        step(12);
        rst = 1'b0;
        check(cnt, 16'h0000);
        check({14'h0, overflow_flag, gate_event_flag}, 16'h0);
        put(8'h12, 8'h34);
        step(20);
        check(cnt, 16'h1234);
        $display("test writes done");
        // window is a multiple of every tick period, so phase does not matter
        timer_on_bit = 1'b1;
        for (int c = 0; c < 2; c++) begin
            for (int p = 0; p < 4; p++) begin
                clock_select_field = 2'(1 - c);
                prescale_field = 2'(p);
                step(8);
                rate(64, 16'(64 >> (p + 2 * c)));
            end
        end
        timer_on_bit = 1'b0;
        prescale_field = 2'h0;
        clock_select_field = 2'h1;
        put(8'hff, 8'hf0);
        timer_on_bit = 1'b1;
        step(24);
        timer_on_bit = 1'b0;
        check({15'h0, overflow_flag}, 16'h1);
        overflow_flag_clear = 1'b1;
        step(1);
        overflow_flag_clear = 1'b0;
        check({15'h0, overflow_flag}, 16'h0);
        $display("test rates done");
        // each gate source: shut while low; pin and comparators count every cycle while high, timer zero pulses just move the count
        {gate_enable_bit, gate_polarity_bit, cmp1_sync_select, timer_on_bit} = 4'hf;
        for (int s = 0; s < 4; s++) begin
            gate_source_select = 2'(s);
            {cmp2_sync_select, cmp1_sync_select} = 2'(s);
            m = (s == 1) ? 3'h0 : 3'h1 << (s - (s > 1));
            far.levels(~m);
            step(8);
            rate(20, 16'h0);
            if (s == 1) begin
                base = cnt;
                far.t0_rolls(8);
                check({15'h0, cnt == base}, 16'h0);
            end else begin
                far.levels(m);
                step(8);
                rate(20, 16'd20);
            end
        end
        gate_source_select = 2'h0;
        gate_polarity_bit = 1'b0;
        far.levels(3'h0);
        step(8);
        rate(20, 16'd20);
        check({15'h0, gate_event_flag}, 16'h1);
        gate_event_flag_clear = 1'b1;
        step(1);
        gate_event_flag_clear = 1'b0;
        gate_enable_bit = 1'b0;
        far.levels(3'h1);
        step(8);
        check({15'h0, gate_event_flag}, 16'h1);
        // toggle mode: first pulse opens the gate, second shuts it
        {gate_enable_bit, gate_polarity_bit, gate_toggle_enable} = 3'h7;
        far.levels(3'h0);
        step(8);
        for (int t = 0; t < 2; t++) begin
            far.levels(3'h1);
            step(4);
            far.levels(3'h0);
            step(8);
            rate(20, 16'(20 * (1 - t)));
        end
        gate_toggle_enable = 1'b0;
        {gate_enable_bit, gate_polarity_bit, single_pulse_enable} = 3'h7;
        far.levels(3'h0);
        step(8);
        single_pulse_go_set = 1'b1;
        step(1);
        single_pulse_go_set = 1'b0;
        check({15'h0, single_pulse_go}, 16'h1);
        far.levels(3'h1);
        step(10);
        far.levels(3'h0);
        step(8);
        check({15'h0, single_pulse_go}, 16'h0);
        far.levels(3'h1);
        step(4);
        rate(20, 16'h0);
        single_pulse_go_clear = 1'b1;
        step(1);
        single_pulse_go_clear = 1'b0;
        {gate_enable_bit, single_pulse_enable} = 2'h0;
        $display("test gate done");
        // first rising edge after a write is not counted
        for (int w = 0; w < 3; w++) begin
            for (int y = 0; y < 2; y++) begin
                timer_on_bit = 1'b0;
                clock_select_field = (w == 1) ? 2'h3 : 2'h2;
                crystal_osc_enable = (w == 2);
                sync_disable_bit = 1'(y);
                step(20);
                check({13'h0, crystal_out_pin, crystal_out_oe, crystal_osc_running},
                    16'(w == 2 ? 7 : 4));
                put(8'hff, 8'hf8);
                sleep_mode = 1'(y);
                timer_on_bit = 1'b1;
                wake0 = n_wake;
                step(4);
                far.burst(w, 10);
                step(4);
                check(cnt, 16'h0001);
                check(16'(n_wake - wake0), 16'(y));
                sleep_mode = 1'b0;
            end
        end
        $display("test external done");
        report_and_stop();
    end
endmodule
`default_nettype wire
